// file: hdl/bms_regs.svh
// Register map, field positions, opcodes and timing counts.
// Assumes a 32-bit APB bus with byte addresses.
`ifndef BMS_REGS_SVH
`define BMS_REGS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BMS_OFS_CTRL 8'h00
`define BMS_OFS_STATUS 8'h04
`define BMS_OFS_SRC 8'h08
`define BMS_OFS_DST 8'h0C
`define BMS_OFS_CNT 8'h10
`define BMS_OFS_PC 8'h14
`define BMS_OFS_ACC 8'h18
`define BMS_OFS_FLAGS 8'h1C
// ----------------------------------------
// Fields
// ----------------------------------------
`define BMS_CTRL_START 0
`define BMS_CTRL_OP_LO 1
`define BMS_STAT_BUSY 0
`define BMS_STAT_INT 1
`define BMS_FLAG_S 7
`define BMS_FLAG_Z 6
`define BMS_FLAG_H 4
`define BMS_FLAG_PV 2
`define BMS_FLAG_N 1
`define BMS_FLAG_C 0
// ----------------------------------------
// Opcodes in the control register
// ----------------------------------------
`define BMS_OP_MOVE_DEC 3'h0
`define BMS_OP_MOVE_DEC_REP 3'h1
`define BMS_OP_CMP_INC 3'h2
`define BMS_OP_CMP_INC_REP 3'h3
`define BMS_OP_CMP_DEC 3'h4
`define BMS_OP_CMP_DEC_REP 3'h5
`define BMS_OP_LAST 3'h5
// ----------------------------------------
// Timing in clock states, one per cycle
// ----------------------------------------
`define BMS_T_RD 5'h03
`define BMS_T_SAMPLE 5'h05
`define BMS_T_WR 5'h06
`define BMS_T_WR_END 5'h07
`define BMS_T_RFSH 5'h0B
`define BMS_T_RFSH_END 5'h0D
`define BMS_T_LAST 5'h0F
`define BMS_T_REP_LAST 5'h14
`define BMS_PC_STEP 16'h0002
`define BMS_RST_WORD 16'h0000
`define BMS_RST_BYTE 8'h00
`endif

// file: hdl/bms_pkg.sv
// Types shared by the block-move and block-search engine.
// Assumes bms_regs.svh supplies the numeric constants.
package bms_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_XFER,
		ST_REWIND
	} bms_state_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} bms_apb_req_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} bms_mem_req_t;

	typedef struct packed {
		bms_state_t st;
		logic [2:0] op;
		logic [15:0] src;
		logic [15:0] dst;
		logic [15:0] cnt;
		logic [15:0] pc;
		logic [7:0] acc;
		logic [7:0] flags;
		logic [7:0] data;
		logic [4:0] tcnt;
		bms_mem_req_t mem;
		logic refresh;
		logic int_ack;
		logic int_seen;
	} bms_core_t;
endpackage

// file: hdl/bms_exec.sv
// Block move and block search execution engine with APB registers.
// Assumes memory answers a read in the cycle after mem.rd is high.
// How it works
// - Repeat move copies source byte to destination
// - Each move decrements source, destination, counter
// - Repeat move ends when counter hits zero
// - Nonzero counter rewinds program counter by two
// - Interrupts between iterations, two refresh cycles
// - Zero counter at start wraps through 64K
// - Compare subtracts memory from accumulator, flags only
// - Increment compare: source up, counter down
// - Repeat compare stops on zero or match
// - Decrement compare: source and counter down
// - Repeat decrement compare updates before testing
// - Sign from result, subtract set, carry kept
// - Zero flag set exactly on equality
// - Half flag set on borrow from bit four
// - Parity flag shows counter still nonzero
// - Compare never writes accumulator or memory
// - Single move copies and decrements once
`include "bms_regs.svh"

module bms_exec (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire bms_pkg::bms_apb_req_t apb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output bms_pkg::bms_mem_req_t mem_out,
	input wire logic [7:0] mem_rdata_in,
	output logic refresh_out,
	input wire logic int_req_in,
	output logic int_ack_out,
	output logic busy_out
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] dec16(
		input logic [15:0] v);
		dec16 = v - 16'h0001;
	endfunction

	function automatic logic [15:0] inc16(
		input logic [15:0] v);
		inc16 = v + 16'h0001;
	endfunction

	function automatic logic is_rep(input logic [2:0] op);
		is_rep = (op == `BMS_OP_MOVE_DEC_REP) ||
			(op == `BMS_OP_CMP_INC_REP) ||
			(op == `BMS_OP_CMP_DEC_REP);
	endfunction

	function automatic logic is_cmp(input logic [2:0] op);
		is_cmp = (op == `BMS_OP_CMP_INC) ||
			(op == `BMS_OP_CMP_INC_REP) ||
			(op == `BMS_OP_CMP_DEC) ||
			(op == `BMS_OP_CMP_DEC_REP);
	endfunction

	function automatic logic is_inc(input logic [2:0] op);
		is_inc = (op == `BMS_OP_CMP_INC) ||
			(op == `BMS_OP_CMP_INC_REP);
	endfunction

	function automatic logic is_reg(input logic [7:0] a);
		is_reg = (a == `BMS_OFS_CTRL) ||
			(a == `BMS_OFS_STATUS) ||
			(a == `BMS_OFS_SRC) ||
			(a == `BMS_OFS_DST) ||
			(a == `BMS_OFS_CNT) ||
			(a == `BMS_OFS_PC) ||
			(a == `BMS_OFS_ACC) ||
			(a == `BMS_OFS_FLAGS);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	bms_pkg::bms_core_t core_reg;
	bms_pkg::bms_core_t core_next;

	logic wr_acc;
	logic idle;
	logic [15:0] cnt_dec;
	logic [8:0] diff;
	logic [4:0] nib;
	logic match;
	logic more;
	logic [7:0] fl;

	assign idle = (core_reg.st == bms_pkg::ST_IDLE);
	assign wr_acc = apb_in.psel && apb_in.penable &&
		apb_in.pwrite;
	assign cnt_dec = dec16(core_reg.cnt);
	// Flags only: the difference is never stored
	assign diff = {1'b0, core_reg.acc} -
		{1'b0, core_reg.data};
	assign nib = {1'b0, core_reg.acc[3:0]} -
		{1'b0, core_reg.data[3:0]};
	assign match = (core_reg.acc == core_reg.data);
	assign more = (cnt_dec != `BMS_RST_WORD);

	// ----------------------------------------
	// Flag update at the end of an iteration
	// ----------------------------------------
	always_comb begin
		fl = core_reg.flags;
		fl[`BMS_FLAG_PV] = more;
		if (is_cmp(core_reg.op)) begin
			fl[`BMS_FLAG_S] = diff[7];
			fl[`BMS_FLAG_Z] = match;
			fl[`BMS_FLAG_H] = nib[4];
			fl[`BMS_FLAG_N] = 1'b1;
		end else begin
			// Sign, zero and carry stay as they were
			fl[`BMS_FLAG_H] = 1'b0;
			fl[`BMS_FLAG_N] = 1'b0;
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		core_next = core_reg;
		core_next.refresh = 1'b0;
		core_next.int_ack = 1'b0;
		// Registers are locked while an instruction runs
		if (wr_acc && idle) begin
			unique case (apb_in.paddr)
				`BMS_OFS_SRC:
					core_next.src = apb_in.pwdata[15:0];
				`BMS_OFS_DST:
					core_next.dst = apb_in.pwdata[15:0];
				`BMS_OFS_CNT:
					core_next.cnt = apb_in.pwdata[15:0];
				`BMS_OFS_PC:
					core_next.pc = apb_in.pwdata[15:0];
				`BMS_OFS_ACC:
					core_next.acc = apb_in.pwdata[7:0];
				`BMS_OFS_FLAGS:
					core_next.flags = apb_in.pwdata[7:0];
				`BMS_OFS_CTRL: begin
					if (apb_in.pwdata[`BMS_CTRL_START] &&
						(apb_in.pwdata[3:1] <=
						`BMS_OP_LAST)) begin
						core_next.op = apb_in.pwdata[3:1];
						core_next.st = bms_pkg::ST_XFER;
						core_next.tcnt = 5'h00;
						core_next.int_seen = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		unique case (core_reg.st)
			bms_pkg::ST_IDLE: begin
			end
			bms_pkg::ST_XFER: begin
				core_next.tcnt = core_reg.tcnt + 5'h01;
				if (core_reg.tcnt == `BMS_T_RD) begin
					core_next.mem.rd = 1'b1;
					core_next.mem.addr =
						core_reg.src;
				end
				if (core_reg.tcnt == `BMS_T_RD + 5'h01)
					core_next.mem.rd = 1'b0;
				if (core_reg.tcnt == `BMS_T_SAMPLE)
					core_next.data = mem_rdata_in;
				// Compares never drive the write strobe
				if ((core_reg.tcnt == `BMS_T_WR) &&
					!is_cmp(core_reg.op)) begin
					core_next.mem.wr = 1'b1;
					core_next.mem.addr =
						core_reg.dst;
					core_next.mem.wdata =
						core_reg.data;
				end
				if (core_reg.tcnt == `BMS_T_WR_END)
					core_next.mem.wr = 1'b0;
				// Two refresh cycles follow each transfer
				if ((core_reg.tcnt >= `BMS_T_RFSH) &&
					(core_reg.tcnt < `BMS_T_RFSH_END))
					core_next.refresh = 1'b1;
				if (core_reg.tcnt == `BMS_T_LAST) begin
					core_next.flags = fl;
					// Counter wraps, so a zero start runs 64K
					core_next.cnt =
						cnt_dec;
					if (is_inc(core_reg.op))
						core_next.src =
							inc16(core_reg.src);
					else
						core_next.src =
							dec16(core_reg.src);
					if (!is_cmp(core_reg.op))
						core_next.dst =
							dec16(core_reg.dst);
					// Test follows the update above
					if (is_rep(core_reg.op) && more &&
						!(is_cmp(core_reg.op) &&
						match)) begin
						core_next.pc = core_reg.pc -
							`BMS_PC_STEP;
						core_next.st =
							bms_pkg::ST_REWIND;
					end else begin
						core_next.st =
							bms_pkg::ST_IDLE;
						core_next.pc = core_reg.pc;
					end
				end
			end
			bms_pkg::ST_REWIND: begin
				core_next.tcnt = core_reg.tcnt + 5'h01;
				if (core_reg.tcnt == `BMS_T_REP_LAST) begin
					core_next.tcnt = 5'h00;
					// Pending interrupt leaves with PC rewound
					if (int_req_in) begin
						core_next.st =
							bms_pkg::ST_IDLE;
						core_next.int_ack = 1'b1;
						core_next.int_seen = 1'b1;
					end else begin
						core_next.st =
							bms_pkg::ST_XFER;
						// Refetch of the rewound instruction moves PC on
						core_next.pc = core_reg.pc +
							`BMS_PC_STEP;
					end
				end
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			core_reg.st <= bms_pkg::ST_IDLE;
			core_reg.op <= `BMS_OP_MOVE_DEC;
			core_reg.src <= `BMS_RST_WORD;
			core_reg.dst <= `BMS_RST_WORD;
			core_reg.cnt <= `BMS_RST_WORD;
			core_reg.pc <= `BMS_RST_WORD;
			core_reg.acc <= `BMS_RST_BYTE;
			core_reg.flags <= `BMS_RST_BYTE;
			core_reg.data <= `BMS_RST_BYTE;
			core_reg.tcnt <= 5'h00;
			core_reg.mem.rd <= 1'b0;
			core_reg.mem.wr <= 1'b0;
			core_reg.mem.addr <= `BMS_RST_WORD;
			core_reg.mem.wdata <= `BMS_RST_BYTE;
			core_reg.refresh <= 1'b0;
			core_reg.int_ack <= 1'b0;
			core_reg.int_seen <= 1'b0;
		end else if (ce_in) begin
			core_reg <= core_next;
		end
	end

	// ----------------------------------------
	// APB read side
	// ----------------------------------------
	// Zero-wait slave: reads come from stored state
	always_comb begin
		prdata_out = 32'h00000000;
		unique case (apb_in.paddr)
			`BMS_OFS_CTRL:
				prdata_out[3:1] = core_reg.op;
			`BMS_OFS_STATUS: begin
				prdata_out[`BMS_STAT_BUSY] = !idle;
				prdata_out[`BMS_STAT_INT] =
					core_reg.int_seen;
			end
			`BMS_OFS_SRC: prdata_out[15:0] = core_reg.src;
			`BMS_OFS_DST: prdata_out[15:0] = core_reg.dst;
			`BMS_OFS_CNT: prdata_out[15:0] = core_reg.cnt;
			`BMS_OFS_PC: prdata_out[15:0] = core_reg.pc;
			`BMS_OFS_ACC: prdata_out[7:0] = core_reg.acc;
			`BMS_OFS_FLAGS:
				prdata_out[7:0] = core_reg.flags;
			default: begin
			end
		endcase
	end

	assign pready_out = 1'b1;
	assign pslverr_out = apb_in.psel && apb_in.penable &&
		!is_reg(apb_in.paddr);
	assign mem_out = core_reg.mem;
	assign refresh_out = core_reg.refresh;
	assign int_ack_out = core_reg.int_ack;
	assign busy_out = !idle;

endmodule

// file: tb/bms_mem_model.sv
// Byte-wide memory on the far side of the engine.
// Assumes reads are answered one cycle after the strobe, no waits.
module bms_mem_model (
	input wire logic clk_in,
	input wire bms_pkg::bms_mem_req_t mem_in,
	output logic [7:0] rdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] bytes [0:65535];
	initial rdata_out = 8'h00;
	// Data stands one cycle, then toggles so a stale byte never matches
	always @(posedge clk_in) begin
		if (mem_in.rd) begin
			rdata_out <= bytes[mem_in.addr];
		end else begin
			rdata_out <= ~rdata_out;
		end
		if (mem_in.wr) begin
			bytes[mem_in.addr] <= mem_in.wdata;
		end
	end
endmodule

// file: tb/bms_exec_chk.sv
// Port checker for the block move and search engine.
// Assumes it is bound to bms_exec.
module bms_exec_chk (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire bms_pkg::bms_mem_req_t mem_out,
	input wire logic [7:0] mem_rdata_in,
	input wire logic refresh_out,
	input wire logic int_req_in,
	input wire logic int_ack_out,
	input wire logic busy_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	property p_rf;
		$rose(refresh_out) |=> refresh_out ##1 !refresh_out;
	endproperty
	a_rf: assert property (p_rf) else $error("refresh length");
	property p_rfpos;
		$rose(refresh_out) |-> $past(mem_out.rd, 8);
	endproperty
	a_rfpos: assert property (p_rfpos) else $error("refresh place");
	property p_wr;
		mem_out.wr |-> $past(mem_out.rd, 3) &&
			mem_out.wdata == $past(mem_rdata_in, 2);
	endproperty
	a_wr: assert property (p_wr) else $error("write data");
	property p_end;
		$fell(busy_out) |-> $past(mem_out.rd, 12) || int_ack_out;
	endproperty
	a_end: assert property (p_end) else $error("final length");
	property p_rep;
		$rose(refresh_out) |-> ##13 (mem_out.rd || !busy_out);
	endproperty
	a_rep: assert property (p_rep) else $error("repeat length");
	property p_ack;
		int_ack_out |-> !busy_out && $past(int_req_in, 1) &&
			$past(refresh_out, 8);
	endproperty
	a_ack: assert property (p_ack) else $error("interrupt stop");
	property p_quiet;
		!busy_out |-> !mem_out.wr && !mem_out.rd && !refresh_out;
	endproperty
	a_quiet: assert property (p_quiet) else $error("idle access");
	property p_rdpos;
		mem_out.rd |-> $past(busy_out, 4);
	endproperty
	a_rdpos: assert property (p_rdpos) else $error("read place");
endmodule

// file: tb/bms_exec_tb_top.sv
// Self-checking bench for the block move and search engine.
// Assumes the design, memory model and checker compile first.
`include "bms_regs.svh"
module bms_exec_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_in;
	logic rst_n_in = 1'b0;
	logic ce_in = 1'b1;
	logic int_req_in = 1'b0;
	bms_pkg::bms_apb_req_t apb_in = '0;
	logic [31:0] prdata_out;
	logic pready_out;
	logic pslverr_out;
	bms_pkg::bms_mem_req_t mem_out;
	logic [7:0] mem_rdata_in;
	logic refresh_out;
	logic int_ack_out;
	logic busy_out;
	logic [31:0] rd_val;
	logic perr;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	int n;
	bms_exec dut (.*);
	bms_mem_model mem (.clk_in(core_clk_in), .mem_in(mem_out),
		.rdata_out(mem_rdata_in));
	// ----------------------------------------
	// Clock, timeout and shared tasks
	// ----------------------------------------
	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end
	always @(posedge core_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		apb_in <= '{1'b1, 1'b0, w, a, d};
		@(posedge core_clk_in);
		apb_in.penable <= 1'b1;
		@(posedge core_clk_in);
		while (pready_out !== 1'b1 && k < 20) begin
			k++;
			@(posedge core_clk_in);
		end
		rd_val = prdata_out;
		perr = pslverr_out;
		// Release, then let an edge pass so the next setup is clean
		apb_in <= '0;
		@(posedge core_clk_in);
	endtask
	task automatic reg_is(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, rd_val, e);
	endtask
	task automatic setup(input logic [15:0] s, t, c,
		input logic [7:0] ac, f);
		apb(1'b1, `BMS_OFS_SRC, {16'h0, s});
		apb(1'b1, `BMS_OFS_DST, {16'h0, t});
		apb(1'b1, `BMS_OFS_CNT, {16'h0, c});
		apb(1'b1, `BMS_OFS_ACC, {24'h0, ac});
		apb(1'b1, `BMS_OFS_FLAGS, {24'h0, f});
		apb(1'b1, `BMS_OFS_PC, 32'h100);
	endtask
	task automatic run(input logic [2:0] op);
		apb(1'b1, `BMS_OFS_CTRL, {28'h0, op, 1'b1});
		n = 0;
		while (busy_out === 1'b1 && n < 2000) begin
			n++;
			@(posedge core_clk_in);
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_move_one();
		mem.bytes[16'h1111] = 8'h88;
		mem.bytes[16'h2222] = 8'h66;
		setup(16'h1111, 16'h2222, 16'h7, 8'h0, 8'hD1);
		run(`BMS_OP_MOVE_DEC);
		chk("len", n, 16);
		chk("byte", mem.bytes[16'h2222], 8'h88);
		reg_is("src", `BMS_OFS_SRC, 32'h1110);
		reg_is("dst", `BMS_OFS_DST, 32'h2221);
		reg_is("cnt", `BMS_OFS_CNT, 32'h6);
		reg_is("flg", `BMS_OFS_FLAGS, 32'hC5);
	endtask
	task automatic t_move_rep();
		mem.bytes[16'h1114] = 8'hA5;
		mem.bytes[16'h1113] = 8'h36;
		mem.bytes[16'h1112] = 8'h88;
		setup(16'h1114, 16'h2225, 16'h3, 8'h0, 8'hFF);
		run(`BMS_OP_MOVE_DEC_REP);
		chk("len", n, 58);
		chk("b0", mem.bytes[16'h2225], 8'hA5);
		chk("b1", mem.bytes[16'h2224], 8'h36);
		chk("b2", mem.bytes[16'h2223], 8'h88);
		reg_is("src", `BMS_OFS_SRC, 32'h1111);
		reg_is("dst", `BMS_OFS_DST, 32'h2222);
		reg_is("cnt", `BMS_OFS_CNT, 32'h0);
		reg_is("pc", `BMS_OFS_PC, 32'h100);
		reg_is("flg", `BMS_OFS_FLAGS, 32'hE9);
	endtask
	task automatic t_wrap_int();
		mem.bytes[16'h0000] = 8'h5A;
		int_req_in <= 1'b1;
		setup(16'h0, 16'h3000, 16'h0, 8'h0, 8'h0);
		run(`BMS_OP_MOVE_DEC_REP);
		chk("len", n, 21);
		chk("ack", int_ack_out, 1'b1);
		int_req_in <= 1'b0;
		chk("byte", mem.bytes[16'h3000], 8'h5A);
		reg_is("cnt", `BMS_OFS_CNT, 32'hFFFF);
		reg_is("src", `BMS_OFS_SRC, 32'hFFFF);
		reg_is("dst", `BMS_OFS_DST, 32'h2FFF);
		reg_is("pc", `BMS_OFS_PC, 32'hFE);
		reg_is("stat", `BMS_OFS_STATUS, 32'h2);
	endtask
	task automatic t_search();
		mem.bytes[16'h1111] = 8'h52;
		mem.bytes[16'h1112] = 8'h00;
		mem.bytes[16'h1113] = 8'hF3;
		setup(16'h1111, 16'h0, 16'h7, 8'hF3, 8'h01);
		run(`BMS_OP_CMP_INC_REP);
		chk("len", n, 58);
		reg_is("src", `BMS_OFS_SRC, 32'h1114);
		reg_is("cnt", `BMS_OFS_CNT, 32'h4);
		reg_is("flg", `BMS_OFS_FLAGS, 32'h47);
		reg_is("acc", `BMS_OFS_ACC, 32'hF3);
		mem.bytes[16'h1118] = 8'h52;
		mem.bytes[16'h1117] = 8'h00;
		mem.bytes[16'h1116] = 8'hF3;
		setup(16'h1118, 16'h0, 16'h7, 8'hF3, 8'h00);
		run(`BMS_OP_CMP_DEC_REP);
		chk("len", n, 58);
		reg_is("src", `BMS_OFS_SRC, 32'h1115);
		reg_is("cnt", `BMS_OFS_CNT, 32'h4);
		reg_is("flg", `BMS_OFS_FLAGS, 32'h46);
	endtask
	task automatic t_cmp_one();
		mem.bytes[16'h4000] = 8'h01;
		setup(16'h4000, 16'h0, 16'h1, 8'h10, 8'h00);
		run(`BMS_OP_CMP_INC);
		chk("len", n, 16);
		chk("mem", mem.bytes[16'h4000], 8'h01);
		reg_is("flg", `BMS_OFS_FLAGS, 32'h12);
		reg_is("src", `BMS_OFS_SRC, 32'h4001);
		reg_is("cnt", `BMS_OFS_CNT, 32'h0);
		reg_is("acc", `BMS_OFS_ACC, 32'h10);
		setup(16'h4000, 16'h0, 16'h2, 8'h00, 8'h01);
		run(`BMS_OP_CMP_DEC);
		reg_is("flg", `BMS_OFS_FLAGS, 32'h97);
		reg_is("src", `BMS_OFS_SRC, 32'h3FFF);
		reg_is("cnt", `BMS_OFS_CNT, 32'h1);
		apb(1'b0, 8'h20, 32'h0);
		chk("perr", perr, 1'b1);
	endtask
	// Clock enable low must stretch the run, not shorten it
	task automatic t_freeze();
		mem.bytes[16'h5000] = 8'h33;
		setup(16'h5000, 16'h0, 16'h3, 8'h33, 8'h00);
		apb(1'b1, `BMS_OFS_CTRL, {28'h0, `BMS_OP_CMP_INC, 1'b1});
		ce_in <= 1'b0;
		repeat (5) @(posedge core_clk_in);
		ce_in <= 1'b1;
		n = 0;
		while (busy_out === 1'b1 && n < 2000) begin
			n++;
			@(posedge core_clk_in);
		end
		chk("frz", n, 16);
		reg_is("flg", `BMS_OFS_FLAGS, 32'h46);
		reg_is("src", `BMS_OFS_SRC, 32'h5001);
	endtask
	initial begin
		repeat (20) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		@(posedge core_clk_in);
		t_move_one();
		t_move_rep();
		t_wrap_int();
		t_search();
		t_cmp_one();
		t_freeze();
		report_and_stop();
	end
	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
endmodule
bind bms_exec bms_exec_chk u_chk (.*);
